// ---- civr_pkg.sv ----
// Constants, types and register map for the interrupt vectoring and reset block.
// Assumes a single 10 MHz clock and a synchronous active-low reset.
package civr_pkg;

	localparam int unsigned CLK_PERIOD_NS = 100;
	// Internal processing interval after reset release, in ns
	localparam int unsigned RESET_INTERVAL_NS = 700;
	localparam int unsigned RESET_INTERVAL_CYC =
		(RESET_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Vector types
	localparam logic [7:0] VT_DIVIDE    = 8'h00;
	localparam logic [7:0] VT_NMI       = 8'h02;
	localparam logic [7:0] VT_BREAK     = 8'h03;
	localparam logic [7:0] VT_OVERFLOW  = 8'h04;
	localparam logic [7:0] VT_BOUNDS    = 8'h05;
	localparam logic [7:0] VT_UNUSED_OP = 8'h06;
	localparam logic [7:0] VT_ESCAPE    = 8'h07;
	localparam logic [7:0] VT_TIMER0    = 8'h08;
	localparam logic [7:0] VT_DMA0      = 8'h0A;
	localparam logic [7:0] VT_DMA1      = 8'h0B;
	localparam logic [7:0] VT_EXT0      = 8'h0C;
	localparam logic [7:0] VT_TIMER1    = 8'h12;
	localparam logic [7:0] VT_TIMER2    = 8'h13;

	// Default priority levels (lower wins)
	localparam logic [3:0] PRI_TIMER = 4'h2;
	localparam logic [3:0] PRI_DMA   = 4'h5;
	localparam logic [3:0] PRI_EXT0  = 4'h6;
	localparam logic [3:0] PRI_NONE  = 4'hF;

	localparam logic [7:0] ESC_OPCODE_LO = 8'hD8;
	localparam logic [7:0] ESC_OPCODE_MASK = 8'hF8;
	localparam int unsigned PSW_IF_BIT = 9;
	localparam int unsigned PSW_TF_BIT = 8;
	localparam int unsigned PSW_OF_BIT = 11;

	// Reset values
	localparam logic [15:0] RST_PSW   = 16'hF002;
	localparam logic [15:0] RST_IP    = 16'h0000;
	localparam logic [15:0] RST_CS    = 16'hFFFF;
	localparam logic [15:0] RST_SEG   = 16'h0000;
	localparam logic [15:0] RST_RELOC = 16'h20FF;
	localparam logic [15:0] RST_UPPER_MEMORY_CHIP_SELECT  = 16'hFFFB;
	localparam logic [15:0] ZERO16    = 16'h0000;

	// Register word offsets (byte address = 4 * index)
	localparam logic [3:0] REG_PSW     = 4'h0;
	localparam logic [3:0] REG_IP      = 4'h1;
	localparam logic [3:0] REG_CS      = 4'h2;
	localparam logic [3:0] REG_DS      = 4'h3;
	localparam logic [3:0] REG_ES      = 4'h4;
	localparam logic [3:0] REG_SS      = 4'h5;
	localparam logic [3:0] REG_RELOC   = 4'h6;
	localparam logic [3:0] REG_UPPER_MEMORY_CHIP_SELECT    = 4'h7;
	localparam logic [3:0] REG_CTRL    = 4'h8;
	localparam logic [3:0] REG_SLVVEC  = 4'h9;
	localparam logic [3:0] REG_STATUS  = 4'hA;
	localparam logic [3:0] REG_SP      = 4'hB;
	localparam logic [31:0] UNMAPPED_RD = 32'hDEAD_BEEF;

	// Control register fields
	localparam int unsigned CTRL_SLAVE_BIT = 0;
	localparam int unsigned CTRL_UNIQUE_BIT = 1;

	typedef enum logic [2:0] {
		ST_RESET  = 3'b000,
		ST_RUN    = 3'b001,
		ST_PUSH   = 3'b011,
		ST_VECTOR = 3'b010,
		ST_INTERRUPT_RETURN   = 3'b110
	} civr_state_e;

	// Instruction-boundary report from the execution unit
	typedef struct packed {
		logic        boundary;
		logic [7:0]  opcode;
		logic        seg_prefix;
		logic        is_into;
		logic        bound_check;
		logic [15:0] bound_index;
		logic [15:0] bound_lo;
		logic [15:0] bound_hi;
		logic        undefined_op;
		logic        int_instr;
		logic [7:0]  int_type;
		logic        divide_error;
		logic        interrupt_return;
		logic [15:0] instr_ip;
		logic [15:0] prefix_ip;
		logic [15:0] next_ip;
	} civr_exec_s;

	// Maskable hardware request lines
	typedef struct packed {
		logic [2:0] timer;
		logic [1:0] dma;
		logic [3:0] ext;
	} civr_req_s;

	// Memory port toward the stack and vector table
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [19:0] addr;
		logic [15:0] wdata;
	} civr_mem_s;

	function automatic logic [19:0] civr_phys(input logic [15:0] seg, input logic [15:0] off);
		civr_phys = {seg, 4'h0} + {4'h0, off};
	endfunction : civr_phys

endpackage : civr_pkg

// ---- civr_arbiter.sv ----
// Priority arbiter for maskable hardware requests.
// Assumes requests are levels held until serviced.
`timescale 1ns/1ps
`default_nettype none
module civr_arbiter
	import civr_pkg::*;
(
	input  wire civr_req_s  req,
	input  wire logic       slave_mode,
	input  wire logic       unique_pri,
	input  wire logic [3:0] pri_dma,
	input  wire logic [3:0] pri_ext,
	input  wire logic [7:0] slave_timer_base,
	input  wire logic [7:0] slave_dma_base,
	output var  logic       hit,
	output var  logic [7:0] vtype
);

	logic [3:0] best_pri;
	logic [3:0] lvl;
	logic [7:0] tvec;

	always_comb begin
		hit = 1'b0;
		vtype = VT_DIVIDE;
		best_pri = PRI_NONE;
		tvec = VT_TIMER0;
		lvl = PRI_NONE;
		// Timers share one level; timer 0 over 1 over 2
		if (req.timer[0]) begin
			tvec = slave_mode ? slave_timer_base : VT_TIMER0;
		end else if (req.timer[1]) begin
			tvec = slave_mode ? slave_timer_base + 8'h01 : VT_TIMER1;
		end else if (req.timer[2]) begin
			tvec = slave_mode ? slave_timer_base + 8'h02 : VT_TIMER2;
		end
		if (|req.timer) begin
			hit = 1'b1;
			vtype = tvec;
			best_pri = PRI_TIMER;
		end
		for (int i = 0; i < 2; i++) begin
			lvl = unique_pri ? pri_dma : PRI_DMA;
			if (req.dma[i] && lvl < best_pri) begin
				hit = 1'b1;
				best_pri = lvl;
				vtype = (slave_mode ? slave_dma_base : VT_DMA0) + 8'(i);
			end
		end
		for (int i = 0; i < 4; i++) begin
			lvl = unique_pri ? pri_ext : PRI_EXT0 + 4'(i);
			if (req.ext[i] && lvl < best_pri) begin
				hit = 1'b1;
				best_pri = lvl;
				vtype = VT_EXT0 + 8'(i);
			end
		end
	end

endmodule : civr_arbiter
`default_nettype wire

// ---- civr_core.sv ----
// Interrupt and exception vectoring with processor reset sequencing.
// Assumes an execution unit reporting instruction boundaries and memory answering one cycle after each read.
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module civr_core
	import civr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire civr_exec_s  exec,
	input  wire civr_req_s   req,
	input  wire logic        nmi,
	input  wire logic [15:0] mem_rdata,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output civr_mem_s        mem,
	output logic             running,
	output logic             fetch_valid,
	output logic [19:0]      fetch_addr,
	output logic             service_pulse,
	output logic [7:0]       service_type
);

	civr_state_e state_reg;
	logic [15:0] psw_reg, ip_reg, cs_reg, ds_reg, es_reg, ss_reg, sp_reg;
	logic [15:0] reloc_reg, upper_memory_chip_select_reg, saved_psw_reg;
	logic [7:0]  ctrl_reg;
	logic [15:0] slvvec_reg;
	logic [15:0] ret_ip_reg;
	logic [7:0]  vtype_reg;
	logic [1:0]  step_reg;
	logic [7:0]  rst_cnt_reg;
	logic        nmi_prev_reg, nmi_pend_reg;
	logic        ack_reg;
	logic        arb_hit;
	logic [7:0]  arb_vtype;
	logic        take_int;
	logic [7:0]  take_type;
	logic [15:0] take_ret;
	logic        is_interrupt_return;
	logic        interrupt_return_pend;
	logic        avs_req;

	function automatic logic [15:0] vec_addr(input logic [7:0] vt);
		vec_addr = {6'h00, vt, 2'b00};
	endfunction : vec_addr

	civr_arbiter u_arb (
		.req              (req),
		.slave_mode       (ctrl_reg[CTRL_SLAVE_BIT]),
		.unique_pri       (ctrl_reg[CTRL_UNIQUE_BIT]),
		.pri_dma          (ctrl_reg[7:4]),
		.pri_ext          (slvvec_reg[15:12]),
		.slave_timer_base ({slvvec_reg[7:3], 3'b000}),
		.slave_dma_base   ({slvvec_reg[11:8], 4'h0}),
		.hit              (arb_hit),
		.vtype            (arb_vtype)
	);

	// Software events from the current instruction win; hardware after.
	always_comb begin
		take_int = 1'b0;
		take_type = VT_DIVIDE;
		take_ret = exec.next_ip;
		is_interrupt_return = 1'b0;
		if (state_reg == ST_RUN && exec.boundary) begin
			if ((exec.opcode & ESC_OPCODE_MASK) == ESC_OPCODE_LO) begin
				take_int = 1'b1;
				take_type = VT_ESCAPE;
				take_ret = exec.seg_prefix ? exec.prefix_ip : exec.instr_ip;
			end else if (exec.undefined_op) begin
				take_int = 1'b1;
				take_type = VT_UNUSED_OP;
			end else if (exec.divide_error) begin
				take_int = 1'b1;
				take_type = VT_DIVIDE;
			end else if (exec.is_into && psw_reg[PSW_OF_BIT]) begin
				take_int = 1'b1;
				take_type = VT_OVERFLOW;
			end else if (exec.bound_check &&
				($signed(exec.bound_index) < $signed(exec.bound_lo) ||
				 $signed(exec.bound_index) > $signed(exec.bound_hi))) begin
				take_int = 1'b1;
				take_type = VT_BOUNDS;
			end else if (exec.int_instr) begin
				take_int = 1'b1;
				take_type = exec.int_type;
			end else if (exec.interrupt_return) begin
				is_interrupt_return = 1'b1;
			end else if (nmi_pend_reg) begin
				take_int = 1'b1;
				take_type = VT_NMI;
			end else if (arb_hit && psw_reg[PSW_IF_BIT]) begin
				take_int = 1'b1;
				take_type = arb_vtype;
			end
		end else if (state_reg == ST_INTERRUPT_RETURN && step_reg == 2'b11) begin
			take_ret = ip_reg;
			if (nmi_pend_reg) begin
				take_int = 1'b1;
				take_type = VT_NMI;
			end else if (arb_hit && mem_rdata[PSW_IF_BIT]) begin
				take_int = 1'b1;
				take_type = arb_vtype;
			end
		end
	end

	assign interrupt_return_pend = nmi_pend_reg || (arb_hit && saved_psw_reg[PSW_IF_BIT]);
	assign avs_req = (avs_read || avs_write) && !ack_reg;

	// NMI edge latch; new edge wins over the clear
	always_ff @(posedge clock) begin
		if (!resetn) begin
			nmi_prev_reg <= 1'b0;
			nmi_pend_reg <= 1'b0;
		end else begin
			nmi_prev_reg <= nmi;
			if (nmi && !nmi_prev_reg) begin
				nmi_pend_reg <= 1'b1;
			end else if (take_int && take_type == VT_NMI && !exec.int_instr) begin
				nmi_pend_reg <= 1'b0;
			end
		end
	end

	// Sequencer
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_reg <= ST_RESET;
			rst_cnt_reg <= 8'h00;
			step_reg <= 2'b00;
			vtype_reg <= VT_DIVIDE;
			ret_ip_reg <= RST_IP;
		end else begin
			case (state_reg)
				ST_RESET: begin
					if (rst_cnt_reg == 8'(RESET_INTERVAL_CYC - 1)) begin
						state_reg <= ST_RUN;
					end else begin
						rst_cnt_reg <= rst_cnt_reg + 8'h01;
					end
				end
				ST_RUN: begin
					if (take_int) begin
						state_reg <= ST_PUSH;
						vtype_reg <= take_type;
						ret_ip_reg <= take_ret;
						step_reg <= 2'b00;
					end else if (is_interrupt_return) begin
						state_reg <= ST_INTERRUPT_RETURN;
						step_reg <= 2'b00;
					end
				end
				ST_PUSH: begin
					step_reg <= step_reg + 2'b01;
					if (step_reg == 2'b10) begin
						state_reg <= ST_VECTOR;
						step_reg <= 2'b00;
					end
				end
				ST_VECTOR: begin
					step_reg <= step_reg + 2'b01;
					if (step_reg == 2'b11) begin
						state_reg <= ST_RUN;
					end
				end
				ST_INTERRUPT_RETURN: begin
					step_reg <= step_reg + 2'b01;
					if (step_reg == 2'b11) begin
						state_reg <= take_int ? ST_PUSH : ST_RUN;
						vtype_reg <= take_type;
						ret_ip_reg <= take_ret;
					end
				end
				default: state_reg <= ST_RESET;
			endcase
		end
	end

	// Memory port: push PSW, CS, IP then read offset and segment
	always_ff @(posedge clock) begin
		if (!resetn) begin
			mem <= '0;
		end else begin
			mem <= '0;
			case (state_reg)
				ST_PUSH: begin
					mem.valid <= 1'b1;
					mem.write <= 1'b1;
					mem.addr <= civr_phys(ss_reg, sp_reg - 16'h0002);
					case (step_reg)
						2'b00: mem.wdata <= psw_reg;
						2'b01: mem.wdata <= cs_reg;
						default: mem.wdata <= ret_ip_reg;
					endcase
				end
				// Reads go out two cycles ahead of the register that takes them
				ST_VECTOR: begin
					mem.valid <= !step_reg[1];
					mem.addr <= civr_phys(ZERO16, vec_addr(vtype_reg) + {14'h0000, step_reg[0], 1'b0});
				end
				ST_INTERRUPT_RETURN: begin
					mem.valid <= !step_reg[1];
					mem.addr <= civr_phys(ss_reg, sp_reg);
				end
				ST_RUN: begin
					mem.valid <= is_interrupt_return;
					mem.addr <= civr_phys(ss_reg, sp_reg);
				end
				default: ;
			endcase
		end
	end

	// Stack pointer
	always_ff @(posedge clock) begin
		if (!resetn) begin
			sp_reg <= RST_SEG;
		end else if (state_reg == ST_PUSH) begin
			sp_reg <= sp_reg - 16'h0002;
		end else if (is_interrupt_return || (state_reg == ST_INTERRUPT_RETURN && !step_reg[1])) begin
			sp_reg <= sp_reg + 16'h0002;
		end else if (avs_write && avs_req && avs_address[5:2] == REG_SP) begin
			sp_reg <= avs_writedata[15:0];
		end
	end

	// Architectural registers, reset values and software writes
	always_ff @(posedge clock) begin
		if (!resetn) begin
			psw_reg <= RST_PSW;
			ip_reg <= RST_IP;
			cs_reg <= RST_CS;
			ds_reg <= RST_SEG;
			es_reg <= RST_SEG;
			ss_reg <= RST_SEG;
			reloc_reg <= RST_RELOC;
			upper_memory_chip_select_reg <= RST_UPPER_MEMORY_CHIP_SELECT;
			saved_psw_reg <= RST_PSW;
			ctrl_reg <= 8'h00;
			slvvec_reg <= 16'h0000;
		end else begin
			if (state_reg == ST_PUSH && step_reg == 2'b00) begin
				saved_psw_reg <= psw_reg;
				psw_reg[PSW_IF_BIT] <= 1'b0;
				psw_reg[PSW_TF_BIT] <= 1'b0;
			end else if (state_reg == ST_VECTOR && step_reg[1]) begin
				if (!step_reg[0]) begin
					ip_reg <= mem_rdata;
				end else begin
					cs_reg <= mem_rdata;
				end
			end else if (state_reg == ST_INTERRUPT_RETURN && step_reg != 2'b00) begin
				case (step_reg)
					2'b01: ip_reg <= mem_rdata;
					2'b10: cs_reg <= mem_rdata;
					default: psw_reg <= mem_rdata;
				endcase
			end else if (state_reg == ST_RUN && exec.boundary && !take_int) begin
				ip_reg <= exec.next_ip;
			end else if (avs_write && avs_req) begin
				case (avs_address[5:2])
					REG_PSW: psw_reg <= avs_writedata[15:0];
					REG_IP: ip_reg <= avs_writedata[15:0];
					REG_CS: cs_reg <= avs_writedata[15:0];
					REG_DS: ds_reg <= avs_writedata[15:0];
					REG_ES: es_reg <= avs_writedata[15:0];
					REG_SS: ss_reg <= avs_writedata[15:0];
					REG_RELOC: reloc_reg <= avs_writedata[15:0];
					REG_UPPER_MEMORY_CHIP_SELECT: upper_memory_chip_select_reg <= avs_writedata[15:0];
					REG_CTRL: ctrl_reg <= avs_writedata[7:0];
					REG_SLVVEC: slvvec_reg <= avs_writedata[15:0];
					default: ;
				endcase
			end
		end
	end

	// Fetch and status outputs
	always_ff @(posedge clock) begin
		if (!resetn) begin
			running <= 1'b0;
			fetch_valid <= 1'b0;
			fetch_addr <= 20'h0_0000;
			service_pulse <= 1'b0;
			service_type <= VT_DIVIDE;
		end else begin
			running <= (state_reg != ST_RESET);
			fetch_valid <= (state_reg == ST_RUN) && !take_int && !is_interrupt_return;
			fetch_addr <= civr_phys(cs_reg, ip_reg);
			service_pulse <= take_int;
			service_type <= take_type;
		end
	end

	// Avalon slave: one wait cycle then answer
	always_ff @(posedge clock) begin
		if (!resetn) begin
			ack_reg <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_reg <= avs_req;
			if (avs_read && avs_req) begin
				case (avs_address[5:2])
					REG_PSW: avs_readdata <= {16'h0000, psw_reg};
					REG_IP: avs_readdata <= {16'h0000, ip_reg};
					REG_CS: avs_readdata <= {16'h0000, cs_reg};
					REG_DS: avs_readdata <= {16'h0000, ds_reg};
					REG_ES: avs_readdata <= {16'h0000, es_reg};
					REG_SS: avs_readdata <= {16'h0000, ss_reg};
					REG_RELOC: avs_readdata <= {16'h0000, reloc_reg};
					REG_UPPER_MEMORY_CHIP_SELECT: avs_readdata <= {16'h0000, upper_memory_chip_select_reg};
					REG_CTRL: avs_readdata <= {24'h00_0000, ctrl_reg};
					REG_SLVVEC: avs_readdata <= {16'h0000, slvvec_reg};
					REG_STATUS: avs_readdata <= {16'h0000, 4'h0, interrupt_return_pend, state_reg, vtype_reg};
					REG_SP: avs_readdata <= {16'h0000, sp_reg};
					default: avs_readdata <= UNMAPPED_RD;
				endcase
			end
		end
	end

	// Waitrequest high except in the answer cycle
	always_ff @(posedge clock) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !avs_req;
		end
	end

endmodule : civr_core
`default_nettype wire

// ---- civr_core_monitor.sv ----
// Checker for the interrupt vectoring core, bound to its ports.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module civr_core_monitor
	import civr_pkg::*;
(
	input wire logic        clock,
	input wire logic        resetn,
	input wire civr_exec_s  exec,
	input wire civr_req_s   req,
	input wire logic        nmi,
	input wire civr_mem_s   mem,
	input wire logic        running,
	input wire logic        fetch_valid,
	input wire logic [19:0] fetch_addr,
	input wire logic        service_pulse,
	input wire logic [7:0]  service_type
);
	logic [3:0] rel_cnt;
	logic       seen_fetch;
	logic [7:0] vt_reg;
	logic       plain;
	assign plain = !exec.undefined_op && !exec.int_instr && !exec.interrupt_return && !exec.is_into
		&& !exec.bound_check && !exec.divide_error && exec.opcode[7:3] != 5'h1B;
	// Saturates so it never wraps back into the quiet window
	always_ff @(posedge clock) begin
		if (!resetn) begin
			rel_cnt <= 4'h0;
		end else if (rel_cnt != 4'hF) begin
			rel_cnt <= rel_cnt + 4'h1;
		end
	end
	always_ff @(posedge clock) begin
		seen_fetch <= resetn && (seen_fetch || fetch_valid);
	end
	always_ff @(posedge clock) begin
		if (service_pulse) begin
			vt_reg <= service_type;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_quiet; rel_cnt < 4'h7 |-> !running && !fetch_valid && !mem.valid; endproperty
	a_quiet: assert property (p_quiet) else $error("activity during reset interval");
	property p_start; rel_cnt == 4'hA |-> running; endproperty
	a_start: assert property (p_start) else $error("core did not start");
	property p_first; fetch_valid && !seen_fetch |-> fetch_addr == 20'hF_FFF0; endproperty
	a_first: assert property (p_first) else $error("first fetch address wrong");
	property p_push; service_pulse |=> (mem.valid && mem.write)[*3]; endproperty
	a_push: assert property (p_push) else $error("entry pushes missing");
	property p_vec;
		service_pulse |-> ##4 (mem.valid && !mem.write && mem.addr == {10'h000, vt_reg, 2'b00})
			##1 (mem.valid && !mem.write && mem.addr == {10'h000, vt_reg, 2'b10});
	endproperty
	a_vec: assert property (p_vec) else $error("vector fetch address wrong");
	// A return's boundary is sampled again once its pops are done
	property p_bnd; service_pulse |-> $past(exec.boundary) || $past(exec.interrupt_return, 5); endproperty
	a_bnd: assert property (p_bnd) else $error("service off a boundary");
	property p_nmi; exec.boundary && running && nmi && plain && req != '0 |=> service_pulse && service_type == 8'h02;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi not taken first");
	property p_esc; exec.boundary && running && exec.opcode[7:3] == 5'h1B |=> service_pulse && service_type == 8'h07;
	endproperty
	a_esc: assert property (p_esc) else $error("escape opcode not trapped");
	property p_undef; exec.boundary && running && exec.undefined_op |=> service_pulse && service_type == 8'h06;
	endproperty
	a_undef: assert property (p_undef) else $error("undefined opcode not trapped");
	property p_tmr;
		service_pulse && (service_type == 8'h12 || service_type == 8'h13)
			|-> !$past(req.timer[0]) && (service_type == 8'h12 || !$past(req.timer[1]));
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer order wrong");
	property p_pri; service_pulse && service_type[7:4] == 4'h0 && service_type[3:1] inside {3'h5, 3'h6, 3'h7}
		|-> $past(req.timer) == 3'h0; endproperty
	a_pri: assert property (p_pri) else $error("default priority wrong");
	c_nmi: cover property (service_pulse && service_type == 8'h02);
	c_esc: cover property (service_pulse && service_type == 8'h07);
	c_ext: cover property (service_pulse && service_type[7:2] == 6'h03);
endmodule : civr_core_monitor
bind civr_core civr_core_monitor mon_u (.clock(clock), .resetn(resetn), .exec(exec), .req(req), .nmi(nmi),
	.mem(mem), .running(running), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
	.service_pulse(service_pulse), .service_type(service_type));
`default_nettype wire

// ---- civr_src_model.sv ----
// Far-side model: interrupt request sources and the vector/stack memory.
// Assumes the core reports each service with a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module civr_src_model
	import civr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire civr_req_s   raise_req,
	input  wire logic        raise_nmi,
	input  wire logic        service_pulse,
	input  wire logic [7:0]  service_type,
	input  wire civr_mem_s   mem,
	output var  civr_req_s   req,
	output var  logic        nmi,
	output var  logic [15:0] mem_rdata
);
	// Levels drop only once served, as a real source would
	always_ff @(posedge clock) begin
		if (!resetn) begin
			req <= '0;
			nmi <= 1'b0;
		end else begin
			req <= req | raise_req;
			nmi <= nmi | raise_nmi;
			if (service_pulse && service_type == 8'h02) nmi <= 1'b0;
			if (service_pulse && service_type == 8'h08) req.timer[0] <= 1'b0;
			if (service_pulse && service_type == 8'h12) req.timer[1] <= 1'b0;
			if (service_pulse && service_type == 8'h13) req.timer[2] <= 1'b0;
			if (service_pulse && service_type[7:1] == 7'h05) req.dma[service_type[0]] <= 1'b0;
			if (service_pulse && service_type[7:2] == 6'h03) req.ext[service_type[1:0]] <= 1'b0;
		end
	end
	// Idle cycles toggle so stale read data is never mistaken for an answer
	always_ff @(posedge clock) begin
		if (!resetn) mem_rdata <= 16'h5A5A;
		else if (mem.valid && !mem.write) mem_rdata <= mem.addr[15:0] + 16'h1000;
		else mem_rdata <= ~mem_rdata;
	end
endmodule : civr_src_model
`default_nettype wire

// ---- civr_core_tb_top.sv ----
// Self-checking bench for the interrupt vectoring core.
// Assumes the source model answers vector reads one cycle after each request.
`timescale 1ns/1ps
`default_nettype none
module civr_core_tb_top;
	import civr_pkg::*;
	logic        clock, resetn, nmi, raise_nmi, avs_read, avs_write, avs_waitrequest;
	logic        running, fetch_valid, service_pulse;
	civr_exec_s  exec, e;
	civr_req_s   req, raise_req;
	civr_mem_s   mem;
	logic [15:0] mem_rdata;
	logic [5:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [19:0] fetch_addr;
	logic [7:0]  service_type;
	logic [15:0] wq[$];
	int          nr, n0, checks, miscompares;
	logic [15:0] rst_tab [8] = '{16'hF002, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h20FF, 16'hFFFB};
	logic [7:0]  seq [5] = '{8'h08, 8'h12, 8'h13, 8'h0B, 8'h0F};
	civr_core dut_u (.clock(clock), .resetn(resetn), .exec(exec), .req(req), .nmi(nmi), .mem_rdata(mem_rdata),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem(mem), .running(running),
		.fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .service_pulse(service_pulse),
		.service_type(service_type));
	civr_src_model src_u (.clock(clock), .resetn(resetn), .raise_req(raise_req), .raise_nmi(raise_nmi),
		.service_pulse(service_pulse), .service_type(service_type), .mem(mem), .req(req), .nmi(nmi),
		.mem_rdata(mem_rdata));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		if (mem.valid === 1'b1 && mem.write === 1'b1) wq.push_back(mem.wdata);
		if (mem.valid === 1'b1 && mem.write === 1'b0) nr++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clock);
		avs_address   <= {idx, 2'b00};
		avs_read      <= !wr;
		avs_write     <= wr;
		avs_writedata <= wd;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		chk(32'(avs_waitrequest), 32'h0000_0000);
	endtask : bus
	task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, idx, 32'h0000_0000, d);
		chk(d, exp);
	endtask : rdc
	task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		bus(1'b1, idx, wd, d);
	endtask : wr
	task automatic raise(input logic n, input logic [8:0] r);
		@(posedge clock);
		raise_nmi <= n;
		raise_req <= r;
		@(posedge clock);
		raise_nmi <= 1'b0;
		raise_req <= '0;
	endtask : raise
	// Bit 8 of t set means no service may follow this boundary
	task automatic step(input civr_exec_s x, input logic [8:0] t);
		logic [15:0] o;
		logic        got;
		int          n;
		o = {6'h00, t[7:0], 2'b00} + 16'h1000;
		got = 1'b0;
		n = 0;
		nr = 0;
		wq.delete();
		x.boundary = 1'b1;
		@(posedge clock);
		exec <= x;
		@(posedge clock);
		exec <= '0;
		// Service after a return comes only once the stack is popped
		repeat (6) begin
			#1;
			if (service_pulse === 1'b1) begin
				got = 1'b1;
				chk(32'(service_type), 32'(t[7:0]));
			end
			@(posedge clock);
		end
		chk(32'(got), 32'(!t[8]));
		while (got && n < 20 && !(nr >= 2 && fetch_valid === 1'b1)) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (got) chk(32'(fetch_addr), 32'({o + 16'h0002, 4'h0} + {4'h0, o}));
	endtask : step
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		#300_000;
		miscompares++;
		give_verdict();
	end
	initial begin
		resetn = 1'b0;
		exec = '0;
		e = '0;
		raise_req = '0;
		raise_nmi = 1'b0;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		checks = 0;
		miscompares = 0;
		n0 = 0;
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		while (fetch_valid !== 1'b1 && n0 < 30) begin
			@(posedge clock);
			#1;
			n0++;
		end
		chk(32'(fetch_addr), 32'h000F_FFF0);
		for (int i = 0; i < 8; i++) rdc(i[3:0], {16'h0000, rst_tab[i]});
		rdc(4'hC, 32'hDEAD_BEEF);
		wr(REG_DS, 32'hABCD_1234);
		rdc(REG_DS, 32'h0000_1234);
		$display("test reset and registers done");
		wr(REG_PSW, 32'h0000_F202);
		raise(1'b1, 9'h001);
		step(e, 9'h002);
		chk(32'(wq[0]), 32'h0000_F202);
		step(e, 9'h100);
		rdc(REG_PSW, 32'h0000_F002);
		raise(1'b1, 9'h000);
		step(e, 9'h002);
		wr(REG_PSW, 32'h0000_F202);
		step(e, 9'h00C);
		raise(1'b0, 9'h1E8);
		for (int i = 0; i < 5; i++) begin
			wr(REG_PSW, 32'h0000_F202);
			step(e, {1'b0, seq[i]});
		end
		$display("test nmi and requests done");
		e.opcode = 8'hD8;
		e.instr_ip = 16'h0124;
		step(e, 9'h007);
		chk(32'(wq[2]), 32'h0000_0124);
		e.opcode = 8'hDF;
		e.seg_prefix = 1'b1;
		e.prefix_ip = 16'h0123;
		step(e, 9'h007);
		chk(32'(wq[2]), 32'h0000_0123);
		e = '0;
		e.is_into = 1'b1;
		step(e, 9'h100);
		wr(REG_PSW, 32'h0000_F802);
		step(e, 9'h004);
		e = '0;
		e.bound_check = 1'b1;
		e.bound_hi = 16'h000F;
		e.bound_index = 16'h000F;
		step(e, 9'h100);
		e.bound_index = 16'h0010;
		step(e, 9'h005);
		e = '0;
		e.undefined_op = 1'b1;
		step(e, 9'h006);
		$display("test exceptions done");
		// Pops read address plus 1000h, so this stack restores status F202
		wr(REG_SP, 32'h0000_E1FE);
		raise(1'b0, 9'h002);
		e = '0;
		e.interrupt_return = 1'b1;
		step(e, 9'h00D);
		chk(32'(wq[0]), 32'h0000_F202);
		chk(32'(wq[2]), 32'h0000_F1FE);
		e = '0;
		wr(REG_CTRL, 32'h0000_0001);
		wr(REG_SLVVEC, 32'h0000_0A40);
		raise(1'b0, 9'h010);
		wr(REG_PSW, 32'h0000_F202);
		step(e, 9'h0A0);
		$display("test return and slave mode done");
		give_verdict();
	end
endmodule : civr_core_tb_top
`default_nettype wire
